// [hw/hsb_pkg.sv]
// Package for the host slave access and DMA bus block
package hsb_pkg;
   // ************************************************
   // Bus cycle timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 20;         // Bus clock period
   localparam int SYNC_STAGES = 2;            // Access synchroniser depth
   localparam int BACK_SLIP_CYCLES = 4;       // Start slip on a missed grant
   localparam int ADDR32_CYCLES = 4;          // Extra address phase length
   localparam int READ_STROBE_CYCLES = 2;     // Memory read strobe length
   localparam int T_CYCLES = 4;               // T1..T4 per transfer
   // ************************************************
   // Bus master states
   // ************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_SLIP,
      ST_ADDR32,
      ST_XFER,
      ST_RELEASE
   } state_type;
endpackage : hsb_pkg

// [hw/hsb_buf2.sv]
// Two-entry skid buffer for DMA read data
module hsb_buf2 #(
   parameter int WIDTH = 16 // Word width
) (
   input wire logic clk, // Bus clock
   input wire logic reset, // Async reset, active high
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word held
   input wire logic out_ready, // Consumer takes word
   output logic [WIDTH-1:0] out_data // Word out, registered
);
   // ************************************************
   // Storage
   // ************************************************
   logic [WIDTH-1:0] mem_reg [2]; // Two entries
   logic [1:0] count_reg; // Entries held
   logic rd_ptr_reg; // Read slot
   logic wr_ptr_reg; // Write slot
   logic push; // Word accepted
   logic pop; // Word delivered

   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_ptr_reg];

   // Entry write, memory needs no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_reg <= 2'h0;
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : hsb_buf2

// [hw/hsb_top.sv]
// Host slave register access and DMA bus master sequencer
// Function
// - Acknowledge only after select, strobe, synchroniser
// - Dual bus: acknowledge waits for DMA end
// - Delay measured from later of select, strobe
// - Latch select lines on strobe fall, else direct
// - Remote: one transfer; local: burst per grant
// - 32-bit mode: address phase before first only
// - Byte burst keeps upper address until last
// - Read strobe held two clocks per cycle
module hsb_top #(
   parameter int BURST_MAX = 8, // Largest local burst length
   parameter int DATA_W = 16 // DMA data width
) (
   input wire logic clk, // Bus clock
   input wire logic reset, // Async reset, active high
   input wire logic chip_select_n, // Host chip select
   input wire logic slave_read_strobe_n, // Host register read
   input wire logic slave_write_strobe_n, // Host register write
   input wire logic host_addr_latch_strobe_n, // Register select latch
   input wire logic latched_mode, // Latch select lines on strobe
   input wire logic dual_bus, // Separate host and buffer buses
   input wire logic [3:0] reg_select_lines, // Register select in
   output logic [3:0] latched_reg_select, // Register in use
   output logic reg_read, // One-cycle read pulse to core
   output logic reg_write, // One-cycle write pulse to core
   output logic ack_n, // Register access acknowledge
   input wire logic local_dma_req, // Local DMA wants a burst
   input wire logic remote_dma_req, // Remote DMA wants a word
   input wire logic [7:0] burst_len, // Local burst length, 1 and up
   input wire logic mode_32bit, // Extra address phase
   input wire logic byte_mode, // Byte-wide transfers
   input wire logic [DATA_W-1:0] mem_rdata, // Memory read data
   output logic bus_request_out, // Bus request
   input wire logic bus_ack, // Bus grant, active high
   output logic bus_ctrl_oe, // Bus control drive enable
   output logic addr_strobe, // Address strobe
   output logic upper_addr_latch_strobe, // Upper address strobe
   output logic upper_addr_oe, // A8-A15 drive enable
   output logic mem_read_n, // Memory read strobe
   output logic first_transfer_cycle, // In T1
   output logic dma_done, // One-cycle pulse at grant end
   output logic rd_valid, // Read word offered
   input wire logic rd_ready, // Consumer ready
   output logic [DATA_W-1:0] rd_data // Read word
);
   // ************************************************
   // Slave access synchroniser
   // ************************************************
   logic access_raw; // Select and a strobe both low
   logic [hsb_pkg::SYNC_STAGES-1:0] sync_reg; // Two-flop synchroniser
   logic access_seen_reg; // Access served, await release
   logic dma_busy; // A transfer is in flight

   // Last of select and strobe opens the access, so both must be low
   assign access_raw = !chip_select_n && (!slave_read_strobe_n || !slave_write_strobe_n);

   // Synchronise the access level to the bus clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= {sync_reg[0], access_raw};
      end
   end

   // Select lines: latched on strobe fall, or flow-through
   logic ads_d_reg; // Previous latch strobe
   logic [3:0] rs_latch_reg; // Latched select
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ads_d_reg <= 1'b1;
         rs_latch_reg <= 4'h0;
      end else begin
         ads_d_reg <= host_addr_latch_strobe_n;
         if (ads_d_reg && !host_addr_latch_strobe_n) begin
            rs_latch_reg <= reg_select_lines;
         end
      end
   end
   assign latched_reg_select = latched_mode ? rs_latch_reg : reg_select_lines;

   // Acknowledge once synced, and in dual bus mode once the DMA is idle.
   // The host is expected to hold its cycle in waits until then.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_n <= 1'b1;
         access_seen_reg <= 1'b0;
         reg_read <= 1'b0;
         reg_write <= 1'b0;
      end else begin
         reg_read <= 1'b0;
         reg_write <= 1'b0;
         if (!sync_reg[1]) begin
            // Release: acknowledge rises a clock after the synced access drops
            ack_n <= 1'b1;
            access_seen_reg <= 1'b0;
         end else if (!access_seen_reg && !(dual_bus && dma_busy)) begin
            ack_n <= 1'b0;
            access_seen_reg <= 1'b1;
            reg_read <= slave_write_strobe_n;
            reg_write <= !slave_write_strobe_n;
         end
      end
   end

   // ************************************************
   // Bus master sequencer
   // ************************************************
   hsb_pkg::state_type state_reg; // Master state
   logic [2:0] cnt_reg; // Cycle within phase
   logic [7:0] xfer_left_reg; // Transfers left in grant
   logic is_local_reg; // Grant serves local DMA
   logic buf_ready; // Buffer has room
   logic last_xfer; // Final transfer in progress
   localparam logic [2:0] TLAST = 3'(hsb_pkg::T_CYCLES - 1);
   localparam logic [2:0] SLIPLAST = 3'(hsb_pkg::BACK_SLIP_CYCLES - 1);
   localparam logic [2:0] A32LAST = 3'(hsb_pkg::ADDR32_CYCLES - 1);
   localparam logic [2:0] RDLAST = 3'(hsb_pkg::READ_STROBE_CYCLES);

   assign dma_busy = (state_reg != hsb_pkg::ST_IDLE);
   assign last_xfer = (xfer_left_reg == 8'h01);

   // Sequencer: request, grant sampled ahead of T1, address phase, transfers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= hsb_pkg::ST_IDLE;
         cnt_reg <= 3'h0;
         xfer_left_reg <= 8'h00;
         is_local_reg <= 1'b0;
      end else begin
         case (state_reg)
            hsb_pkg::ST_IDLE: begin
               cnt_reg <= 3'h0;
               if (local_dma_req) begin
                  is_local_reg <= 1'b1;
                  xfer_left_reg <= (burst_len == 8'h00) ? 8'h01 :
                     ((burst_len > 8'(BURST_MAX)) ? 8'(BURST_MAX) : burst_len);
                  state_reg <= hsb_pkg::ST_REQ;
               end else if (remote_dma_req) begin
                  is_local_reg <= 1'b0;
                  xfer_left_reg <= 8'h01;
                  state_reg <= hsb_pkg::ST_REQ;
               end
            end
            hsb_pkg::ST_REQ: begin
               // Grant must be seen here, ahead of T1
               if (bus_ack) begin
                  state_reg <= mode_32bit ? hsb_pkg::ST_ADDR32 : hsb_pkg::ST_XFER;
               end else begin
                  state_reg <= hsb_pkg::ST_SLIP;
               end
               cnt_reg <= 3'h0;
            end
            hsb_pkg::ST_SLIP: begin
               // Missed grant costs a full four-clock slot
               cnt_reg <= cnt_reg + 3'h1;
               if (cnt_reg == SLIPLAST) begin
                  state_reg <= hsb_pkg::ST_REQ;
               end
            end
            hsb_pkg::ST_ADDR32: begin
               cnt_reg <= cnt_reg + 3'h1;
               if (cnt_reg == A32LAST) begin
                  cnt_reg <= 3'h0;
                  state_reg <= hsb_pkg::ST_XFER;
               end
            end
            hsb_pkg::ST_XFER: begin
               // Hold at T4 while the buffer is full, so no word is lost
               if (cnt_reg == TLAST) begin
                  if (buf_ready) begin
                     cnt_reg <= 3'h0;
                     xfer_left_reg <= xfer_left_reg - 8'h01;
                     if (last_xfer) begin
                        state_reg <= hsb_pkg::ST_RELEASE;
                     end
                  end
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            hsb_pkg::ST_RELEASE: begin
               state_reg <= hsb_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= hsb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // Bus outputs
   // ************************************************
   logic in_xfer; // Transfer cycles active
   assign in_xfer = (state_reg == hsb_pkg::ST_XFER);

   // Request holds from ask until the grant's last transfer ends
   assign bus_request_out = dma_busy && (state_reg != hsb_pkg::ST_RELEASE);
   assign bus_ctrl_oe = in_xfer || (state_reg == hsb_pkg::ST_ADDR32);
   assign first_transfer_cycle = in_xfer && (cnt_reg == 3'h0);
   assign addr_strobe = in_xfer && (cnt_reg == 3'h0);
   assign upper_addr_latch_strobe = (state_reg == hsb_pkg::ST_ADDR32) && (cnt_reg == 3'h0);
   // Read strobe over T2..T3, two full clocks
   assign mem_read_n = !(in_xfer && (cnt_reg >= 3'h1) && (cnt_reg <= RDLAST));
   // Word transfers free A8-A15 at T4; byte bursts hold them until the last,
   // so a stalled T4 in word mode leaves the upper lines to other drivers
   assign upper_addr_oe = (state_reg == hsb_pkg::ST_ADDR32) ||
      (in_xfer && ((cnt_reg != TLAST) || (byte_mode && !last_xfer)));

   // Grant end pulse
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dma_done <= 1'b0;
      end else begin
         dma_done <= (state_reg == hsb_pkg::ST_RELEASE);
      end
   end

   // Capture read data at the end of T4, a clock after the strobe ends, into the skid buffer
   logic cap_valid; // Word sampled this cycle
   assign cap_valid = in_xfer && (cnt_reg == TLAST) && buf_ready;

   hsb_buf2 #(
      .WIDTH(DATA_W)
   ) u_buf (
      .clk(clk),
      .reset(reset),
      .in_valid(cap_valid),
      .in_ready(buf_ready),
      .in_data(mem_rdata),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // ************************************************
   // Checks
   // ************************************************
   ack_after_sync_a: assert property (@(posedge clk) disable iff (reset)
      $fell(ack_n) |-> $past(access_raw, 2) && $past(access_raw, 1))
      else $error("ack fell without synced access");
   ack_dual_bus_a: assert property (@(posedge clk) disable iff (reset)
      $fell(ack_n) |-> !($past(dual_bus) && $past(dma_busy)))
      else $error("ack during DMA in dual bus mode");
   slip_four_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg == hsb_pkg::ST_REQ && !bus_ack) |=> (state_reg == hsb_pkg::ST_SLIP) [*4]
      ##1 (state_reg == hsb_pkg::ST_REQ))
      else $error("missed grant slip not four clocks");
   remote_single_a: assert property (@(posedge clk) disable iff (reset)
      (in_xfer && !is_local_reg) |-> xfer_left_reg == 8'h01)
      else $error("remote DMA doing more than one transfer");
   addr32_first_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg == hsb_pkg::ST_ADDR32) |-> $past(state_reg) != hsb_pkg::ST_XFER)
      else $error("address phase inside a burst");
   read_strobe_a: assert property (@(posedge clk) disable iff (reset)
      $fell(mem_read_n) |=> !mem_read_n ##1 mem_read_n)
      else $error("read strobe not two clocks");
   upper_hold_a: assert property (@(posedge clk) disable iff (reset)
      (in_xfer && byte_mode && !last_xfer) |-> upper_addr_oe)
      else $error("upper address released mid burst");
   req_release_a: assert property (@(posedge clk) disable iff (reset)
      (state_reg == hsb_pkg::ST_RELEASE) |-> !bus_request_out && !bus_ctrl_oe)
      else $error("bus not released at grant end");
endmodule : hsb_top

// [sim/hsb_arb_model.sv]
// Arbiter and memory model on the far side of the DMA bus
module hsb_arb_model (
   input wire logic clk, // Bus clock
   input wire logic reset, // Async reset, active high
   input wire logic slow, // Grant one cycle late
   input wire logic bus_request_out, // Request from block
   input wire logic addr_strobe, // Start of each transfer
   input wire logic mem_read_n, // Memory read strobe
   output logic bus_ack, // Grant, active high
   output logic [15:0] mem_rdata // Memory read data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Grant and memory
   // ****************************************
   logic held_reg; // Request seen at last edge
   logic rd_reg; // Strobe seen at last edge
   logic [15:0] word_reg; // Index of next word
   // Late grant misses the first sample, forcing a slip
   assign bus_ack = bus_request_out && (!slow || held_reg);
   // Data valid from strobe to next transfer; junk otherwise
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         held_reg <= 1'b0;
         rd_reg <= 1'b0;
         word_reg <= 16'h0000;
         mem_rdata <= 16'hFFFF;
      end else begin
         held_reg <= bus_request_out;
         rd_reg <= !mem_read_n;
         if (!mem_read_n && !rd_reg) begin
            mem_rdata <= 16'h5A00 + word_reg;
            word_reg <= word_reg + 16'h0001;
         end else if (addr_strobe || !bus_request_out) begin
            mem_rdata <= ~mem_rdata; // Toggles so a stale capture shows
         end
      end
   end
endmodule : hsb_arb_model

// [sim/tb_top.sv]
// Self-checking bench for the host access and DMA bus block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals and bookkeeping
   // ****************************************
   localparam int BMAX = 8; // Burst ceiling under test
   typedef struct packed {logic [7:0] n, lo, hi; logic byt, fix, a32;} hsb_grant_type; // Grant
   typedef struct packed {logic rd, busy; logic [3:0] sel;} hsb_host_type; // Per access
   logic clk = 1'b0, reset = 1'b1, slow = 1'b0, rd_ready = 1'b1; // Clock and partner knobs
   logic chip_select_n = 1'b1, slave_read_strobe_n = 1'b1, slave_write_strobe_n = 1'b1;
   logic host_addr_latch_strobe_n = 1'b1, latched_mode = 1'b0, dual_bus = 1'b0; // Host modes
   logic [3:0] reg_select_lines = 4'h0, latched_reg_select; // Register select
   logic reg_read, reg_write, ack_n, bus_request_out, bus_ack, bus_ctrl_oe, addr_strobe;
   logic upper_addr_oe, mem_read_n, first_transfer_cycle, dma_done, rd_valid; // Outputs
   logic upper_addr_latch_strobe; // Upper address strobe
   int ua = 0; // Upper strobe pulses in this grant
   logic local_dma_req = 1'b0, remote_dma_req = 1'b0, mode_32bit = 1'b0, byte_mode = 1'b0;
   logic [7:0] burst_len = 8'h01; // Local burst length
   logic [15:0] mem_rdata, rd_data, wexp = 16'h5A00; // Data and next expected word
   logic [1:0] stall = 2'h0; // Consumer: 0 ready, 1 random, 2 blocked
   logic [7:0] lens [8] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'hFF, 8'h03, 8'h05, 8'h02};
   int miscompares = 0, cmp_count = 0, cyc = 0, hcnt = 0, g = 0, nt1 = 0, lat = 0, rs = 0, sp = 0;
   integer seed = 32'h4d87; // Fixed seed
   logic [31:0] r; // Random draw
   bit pp = 1'b0; // Access pulse seen last edge
   hsb_host_type host_q[$], h;
   hsb_grant_type grant_q[$], gx;
   logic [15:0] word_q[$];
   hsb_top #(.BURST_MAX(BMAX), .DATA_W(16)) u_hsb_top (.clk, .reset, .chip_select_n,
      .slave_read_strobe_n, .slave_write_strobe_n, .host_addr_latch_strobe_n, .latched_mode,
      .dual_bus, .reg_select_lines, .latched_reg_select, .reg_read, .reg_write, .ack_n,
      .local_dma_req, .remote_dma_req, .burst_len, .mode_32bit, .byte_mode, .mem_rdata,
      .bus_request_out, .bus_ack, .bus_ctrl_oe, .addr_strobe, .upper_addr_latch_strobe,
      .upper_addr_oe, .mem_read_n, .first_transfer_cycle, .dma_done, .rd_valid, .rd_ready,
      .rd_data);
   hsb_arb_model u_hsb_arb_model (.clk, .reset, .slow, .bus_request_out, .addr_strobe,
      .mem_read_n, .bus_ack, .mem_rdata);
   always #(hsb_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
   // Consumer may stall at random; a full stall fills the buffer
   always @(posedge clk) rd_ready <= (stall == 2'h0) || (stall == 2'h1 && ($random(seed) & 1));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic bit bad(input bit c);
      cmp_count++;
      return c;
   endfunction : bad
   task automatic err(input string m);
      miscompares++;
      $display("Error %0t: %s", $time, m);
   endtask : err
   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // Bounded wait for request (0) or end pulse (1)
   task automatic wt(input bit done);
      int i;
      for (i = 0; i < 3000 && (done ? dma_done : bus_request_out) !== 1'b1; i++) @(posedge clk);
      if (i == 3000) err("wait timed out");
   endtask : wt
   // Host register access; late puts select after the strobe
   task automatic host(input bit rd, input logic [3:0] sel, input bit lt, late, busy);
      int i;
      host_q.push_back('{rd, busy, sel});
      latched_mode <= lt;
      reg_select_lines <= sel;
      @(posedge clk);
      if (lt) begin
         host_addr_latch_strobe_n <= 1'b0;
         repeat (2) @(posedge clk);
         host_addr_latch_strobe_n <= 1'b1;
         reg_select_lines <= ~sel; // Lines change once captured
      end
      chip_select_n <= late;
      slave_read_strobe_n <= !(rd && late);
      slave_write_strobe_n <= !(!rd && late);
      @(posedge clk);
      chip_select_n <= 1'b0;
      slave_read_strobe_n <= !rd;
      slave_write_strobe_n <= rd;
      for (i = 0; i < 3000 && ack_n !== 1'b0; i++) @(posedge clk);
      slave_read_strobe_n <= 1'b1;
      slave_write_strobe_n <= 1'b1;
      chip_select_n <= !late;
      @(posedge clk);
      chip_select_n <= 1'b1;
      for (i = 0; i < 3000 && ack_n !== 1'b1; i++) @(posedge clk);
      if (i == 3000) err("acknowledge stuck");
   endtask : host
   // One local and/or remote request; expectations noted first
   task automatic dma(input bit loc, rem, input logic [7:0] len, input bit m32, byt, sl);
      int n, k, lo;
      n = (len == 8'h00) ? 1 : ((len > BMAX) ? BMAX : int'(len));
      lo = 1 + (sl ? hsb_pkg::BACK_SLIP_CYCLES : 0) + (m32 ? hsb_pkg::ADDR32_CYCLES : 0);
      for (k = 0; k < 2; k++) begin
         if (k == 0 ? loc : rem) begin
            grant_q.push_back('{8'(k == 0 ? n : 1), 8'(lo), 8'(lo + sl), byt,
               stall == 2'h0, m32});
            repeat (k == 0 ? n : 1) begin
               word_q.push_back(wexp);
               wexp = wexp + 16'h0001;
            end
         end
      end
      burst_len <= len;
      mode_32bit <= m32;
      byte_mode <= byt;
      slow <= sl;
      local_dma_req <= loc;
      remote_dma_req <= rem;
      wt(1'b0);
      local_dma_req <= 1'b0;
      remote_dma_req <= loc && rem; // Local goes first, remote waits
      wt(1'b1);
      if (loc && rem) begin
         wt(1'b0);
         remote_dma_req <= 1'b0;
         wt(1'b1);
      end
   endtask : dma
   // ****************************************
   // Monitor: compares against the noted queues
   // ****************************************
   always @(posedge clk) begin
      if (pp && bad({reg_read, reg_write} !== 2'b00)) err("access pulse too long");
      pp = 1'b0;
      if (!chip_select_n && !(slave_read_strobe_n && slave_write_strobe_n) && ack_n === 1'b1) begin
         hcnt++;
      end else if (ack_n === 1'b0 && hcnt != 0) begin
         h = (host_q.size() > 0) ? host_q.pop_front() : '0;
         if (bad(h.busy ? (bus_request_out | bus_ctrl_oe) !== 1'b0
               : hcnt != hsb_pkg::SYNC_STAGES + 1)) err("acknowledge timing");
         if (bad({reg_read, reg_write, latched_reg_select} !== {h.rd, !h.rd, h.sel})) err("decode");
         hcnt = 0;
         pp = 1'b1;
      end
      if (bus_request_out === 1'b1) begin
         if (g == 0) gx = (grant_q.size() > 0) ? grant_q.pop_front() : '0;
         if (first_transfer_cycle === 1'b1) begin
            if (nt1 == 0) lat = g;
            if (nt1 > 0 && gx.fix && bad(sp != hsb_pkg::T_CYCLES)) err("transfer spacing");
            nt1++;
            sp = 0;
         end
         if (nt1 > 0 && bad(upper_addr_oe !== (sp < hsb_pkg::T_CYCLES - 1
               || (gx.byt && nt1 < gx.n)))) err("upper drop");
         if (upper_addr_latch_strobe === 1'b1) ua++;
         g++;
         sp++;
      end else if (g != 0) begin
         if (bad(nt1 != gx.n)) err("transfers per grant");
         if (bad(lat < gx.lo || lat > gx.hi)) err("grant to first transfer");
         if (bad(ua != int'(gx.a32))) err("upper strobe count");
         ua = 0;
         g = 0;
         nt1 = 0;
      end
      if (mem_read_n === 1'b0) begin
         rs++;
      end else if (rs != 0) begin
         if (bad(rs != hsb_pkg::READ_STROBE_CYCLES)) err("read strobe width");
         rs = 0;
      end
      if (dma_done === 1'b1 && bad({bus_request_out, bus_ctrl_oe, upper_addr_oe, mem_read_n}
            !== 4'b0001)) err("bus not released");
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         if (bad(word_q.size() == 0 || word_q[0] !== rd_data)) err("read word");
         if (word_q.size() > 0) void'(word_q.pop_front());
      end
   end
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         dual_bus <= r[0];
         host(i[0], r[7:4], i[1], i[2], 1'b0);
      end
      foreach (lens[i]) dma(1'b1, 1'b0, lens[i], i[0], i[1], i[2]);
      dma(1'b0, 1'b1, 8'h05, 1'b1, 1'b1, 1'b1);
      dma(1'b1, 1'b1, 8'h04, 1'b0, 1'b1, 1'b0);
      stall = 2'h1;
      repeat (6) begin
         r = $random(seed);
         dma(1'b1, r[8], {4'h0, r[3:0]}, r[4], r[5], r[6]);
      end
      stall = 2'h2;
      fork
         dma(1'b1, 1'b0, 8'h06, 1'b0, 1'b0, 1'b0);
         begin
            repeat (60) @(posedge clk);
            if (bad(bus_request_out !== 1'b1 || rd_valid !== 1'b1)) err("stall lost");
            stall <= 2'h1;
         end
      join
      dual_bus <= 1'b1;
      fork
         dma(1'b1, 1'b0, 8'h08, 1'b0, 1'b0, 1'b0);
         begin
            wt(1'b0);
            host(1'b1, 4'hA, 1'b0, 1'b1, 1'b1);
         end
      join
      stall = 2'h0;
      repeat (20) @(posedge clk);
      if (bad(word_q.size() + grant_q.size() + host_q.size() != 0)) err("results missing");
      report_and_stop();
   end
endmodule : tb_top
